// >>> core/acp_params.svh
// constants of the serial command port: field positions, select codes, counts
// assumes inclusion by its bare name from the design files
`ifndef ACP_PARAMS_SVH
`define ACP_PARAMS_SVH

// ****************************************************************
// command byte layout
// ****************************************************************
`define ACP_CMD_OFFSET     3'h0
`define ACP_CMD_RESET      8'h00
`define ACP_CMD_GATE_BIT   7
`define ACP_CMD_DIR_BIT    6
`define ACP_CMD_SEL_HI     5
`define ACP_CMD_SEL_LO     3
`define ACP_CMD_STREAM_BIT 2
`define ACP_CMD_ENTER      8'h5C
`define ACP_CMD_EXIT       8'h58

// ****************************************************************
// register select codes
// ****************************************************************
`define ACP_SEL_COMM       3'h0
`define ACP_SEL_MODE       3'h1
`define ACP_SEL_CONFIG     3'h2
`define ACP_SEL_DATA       3'h3
`define ACP_SEL_IDENT      3'h4
`define ACP_SEL_RESV       3'h5
`define ACP_SEL_OFFSET     3'h6
`define ACP_SEL_FULLSCALE  3'h7

// ****************************************************************
// sizes, reset values and counts
// ****************************************************************
`define ACP_LEN_BYTE       5'h08
`define ACP_LEN_HALF       5'h10
`define ACP_MODE_RESET     24'h00000A
`define ACP_ONES_LIMIT     6'h20
`define ACP_SR_WIDTH       24

`endif

// >>> core/acp_pkg.sv
// types shared by the serial command port design files
// assumes acp_params.svh is compiled alongside
package acp_pkg;

  // ****************************************************************
  // interface states
  // ****************************************************************
  typedef enum logic [1:0] {
    ACP_ST_IDLE   = 2'b00,
    ACP_ST_WRITE  = 2'b01,
    ACP_ST_READ   = 2'b10,
    ACP_ST_STREAM = 2'b11
  } acp_state_t;

  typedef logic [2:0] acp_sel_t;

endpackage

// >>> core/acp_regbank.sv
// register bank of the serial command port: eight words, registered read
// assumes a synchronous active-high reset and one write per cycle
`timescale 1ns/1ps
`include "acp_params.svh"

module acp_regbank #(
  parameter int          DW         = 24,
  parameter logic [23:0] CFG_RESET  = 24'h000000,
  parameter logic [23:0] OFS_RESET  = 24'h800000,
  parameter logic [23:0] FS_RESET   = 24'h500000
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          wr_en,
  input  wire acp_pkg::acp_sel_t wr_addr,
  input  wire logic [23:0]   wr_data,
  input  wire acp_pkg::acp_sel_t rd_addr,
  output logic      [23:0]   rd_data,
  output logic      [23:0]   mode_word,
  output logic      [23:0]   config_word,
  output logic      [23:0]   offset_word,
  output logic      [23:0]   fullscale_word
);

  logic [23:0] mem [0:7];

  // only the two documented word widths are served
  if (DW != 16 && DW != 24) begin : g_bad_width
    $error("bank data width must be 16 or 24");
  end

  // ****************************************************************
  // storage, reset to the documented power-on values
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        mem[i] <= 24'h000000;
      end
      mem[`ACP_SEL_MODE]      <= `ACP_MODE_RESET;
      mem[`ACP_SEL_CONFIG]    <= CFG_RESET;
      mem[`ACP_SEL_OFFSET]    <= OFS_RESET;
      mem[`ACP_SEL_FULLSCALE] <= FS_RESET;
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data out of a register
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= 24'h000000;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

  // words handed to the converter
  assign mode_word      = mem[`ACP_SEL_MODE];
  assign config_word    = mem[`ACP_SEL_CONFIG];
  assign offset_word    = mem[`ACP_SEL_OFFSET];
  assign fullscale_word = mem[`ACP_SEL_FULLSCALE];

endmodule

// >>> core/acp_serial_port.sv
// serial command port of a bridge-sensor converter, host is the serial master
// assumes SCLK, CS_N and DIN are asynchronous pins, converter logic on CLOCK
//
// Function
// R01: every access starts with an 8-bit write-only command byte choosing direction and target
// R02: after the following read or write ends, wait again for a command byte
// R03: after power-up or any reset, start waiting for a command byte
// R04: 32 or more clocks with data input high reset the whole part
// R05: command sent msb first: gate, direction, select x3, stream, two zeros; resets 0
// R06: while the gate bit arrives as 1, stay at the first bit position
// R07: after a 0 gate bit, shift the next seven bits into the command
// R08: direction 0 means write the selected register, 1 means read it
// R09: the three select bits choose the register of the next access
// R10: stream bit with data selected enters continuous read, shifting results after ready
// R11: in continuous read each result is read without a new command byte
// R12: host enters continuous read by sending command 01011100
// R13: command 01011000 while ready is low leaves continuous read
// R14: in continuous read keep watching input for exit and 32-ones reset
// R15: host holds data input low during continuous read between commands
// R16: host writes zeros into the two lowest command bits
// R17: select decode with sizes: comm/status, mode, config, data, id, reserved, offset, fullscale
// R18: shared output goes low at conversion end, high again before next update if unread
// R19: output bits change on the serial clock falling edge while chip select is low
// R20: input bits sampled on the serial clock rising edge, msb first
`timescale 1ns/1ps
`include "acp_params.svh"

module acp_serial_port #(
  parameter int          DW        = 24,
  parameter logic [7:0]  ID_CODE   = 8'h5A,  // arbitrary identification value
  parameter logic [23:0] CFG_RESET = 24'h000000,
  parameter logic [23:0] OFS_RESET = 24'h800000,
  parameter logic [23:0] FS_RESET  = 24'h500000
) (
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic        SCLK,
  input  wire logic        CS_N,
  input  wire logic        DIN,
  output logic             DOUT_RDY,
  output logic             DOUT_OE,
  input  wire logic        CONV_DONE,
  input  wire logic        CONV_WARN,
  input  wire logic [23:0] CONV_DATA,
  input  wire logic        CONV_ERR,
  input  wire logic [2:0]  CONV_CHAN,
  output logic             PART_RESET,
  output logic [23:0]      MODE_WORD,
  output logic [23:0]      CONFIG_WORD,
  output logic [23:0]      OFFSET_WORD,
  output logic [23:0]      FULLSCALE_WORD
);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (DW != 16 && DW != 24) begin : g_bad_width
    $error("data width must be 16 or 24");
  end

  localparam logic [4:0] LEN_WORD = 5'(DW);

  // ****************************************************************
  // functions
  // ****************************************************************
  // transfer length of each selected register
  function automatic logic [4:0] reg_len(input logic [2:0] sel);
    logic [4:0] len;
    len = `ACP_LEN_BYTE;
    unique case (sel)
      `ACP_SEL_MODE, `ACP_SEL_CONFIG:                      len = `ACP_LEN_HALF;
      `ACP_SEL_DATA, `ACP_SEL_OFFSET, `ACP_SEL_FULLSCALE:  len = LEN_WORD;
      default:                                             len = `ACP_LEN_BYTE;
    endcase
    return len;
  endfunction

  // place a value so that its first bit sits at the top of the shifter
  function automatic logic [23:0] left_align(input logic [23:0] v, input logic [4:0] len);
    return v << (5'd24 - len);
  endfunction

  // ****************************************************************
  // signals
  // ****************************************************************
  logic [2:0]         sck_s, cs_s, din_s;
  logic               sck_f, cs_f, din_f;
  logic               sck_new, cs_new, din_new;
  logic               sck_rise, sck_fall;
  logic               rst_all;
  logic [5:0]         ones_cnt;
  acp_pkg::acp_state_t state;
  logic [4:0]         bit_cnt;
  logic [4:0]         xfer_len;
  logic [6:0]         cmd_sr;
  logic [7:0]         cmd_byte;
  logic [6:0]         next_cmd;
  logic [23:0]        in_sr;
  logic [7:0]         hist;
  logic [7:0]         next_hist;
  logic [1:0]         load_pipe;
  logic               stream_busy;
  logic               stream_load;
  logic               wr_en;
  logic               rd_done;
  logic               data_ready;
  logic [23:0]        data_reg;
  logic [23:0]        rd_data;
  logic [23:0]        out_sr;
  logic               dout_bit;
  logic               shifting;
  logic [23:0]        load_val;
  logic [7:0]         status_byte;
  logic [2:0]         sel;

  // ****************************************************************
  // pin sampling: three flops, a change counts once stages two and three agree
  // ****************************************************************
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      sck_s <= 3'h0;
      cs_s  <= 3'h7;
      din_s <= 3'h0;
      sck_f <= 1'b0;
      cs_f  <= 1'b1;
      din_f <= 1'b0;
    end else begin
      sck_s <= {sck_s[1:0], SCLK};
      cs_s  <= {cs_s[1:0], CS_N};
      din_s <= {din_s[1:0], DIN};
      sck_f <= sck_new;
      cs_f  <= cs_new;
      din_f <= din_new;
    end
  end

  assign sck_new  = (sck_s[1] == sck_s[2]) ? sck_s[2] : sck_f;
  assign cs_new   = (cs_s[1] == cs_s[2]) ? cs_s[2] : cs_f;
  assign din_new  = (din_s[1] == din_s[2]) ? din_s[2] : din_f;
  assign sck_rise = sck_new & ~sck_f & ~cs_f;  // [R20]
  assign sck_fall = ~sck_new & sck_f & ~cs_f;  // [R19]

  // ****************************************************************
  // run of ones on the data input resets the whole part
  // ****************************************************************
  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      ones_cnt <= 6'h00;
    end else if (sck_rise) begin
      ones_cnt <= din_f ? ones_cnt + 6'h01 : 6'h00;  // [R04] [R14]
    end
  end

  // one-cycle part reset pulse, also clears this block
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      PART_RESET <= 1'b0;
    end else begin
      PART_RESET <= (ones_cnt == `ACP_ONES_LIMIT) & ~PART_RESET;  // [R04]
    end
  end

  assign rst_all = SYS_RST | PART_RESET;

  // ****************************************************************
  // interface state machine
  // ****************************************************************
  assign next_cmd    = {cmd_sr[5:0], din_f};
  assign next_hist   = {hist[6:0], din_f};
  assign sel         = cmd_byte[`ACP_CMD_SEL_HI:`ACP_CMD_SEL_LO];
  // no reload while the ready clear of a finished word is still pending
  assign stream_load = (state == acp_pkg::ACP_ST_STREAM) & data_ready & ~stream_busy &
                       ~rd_done;  // [R11]

  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      state       <= acp_pkg::ACP_ST_IDLE;  // [R03]
      bit_cnt     <= 5'h00;
      xfer_len    <= 5'h00;
      cmd_sr      <= 7'h00;
      cmd_byte    <= `ACP_CMD_RESET;        // [R05]
      in_sr       <= 24'h000000;
      hist        <= 8'h00;
      load_pipe   <= 2'b00;
      stream_busy <= 1'b0;
      wr_en       <= 1'b0;
      rd_done     <= 1'b0;
    end else begin
      wr_en     <= 1'b0;
      rd_done   <= 1'b0;
      load_pipe <= {load_pipe[0], 1'b0};
      if (stream_load) begin
        stream_busy <= 1'b1;                // [R10]
        bit_cnt     <= 5'h00;
      end
      if (sck_rise) begin
        unique case (state)
          acp_pkg::ACP_ST_IDLE: begin
            if (bit_cnt == 5'h00) begin
              if (!din_f) begin
                bit_cnt <= 5'h01;           // [R06]
              end
            end else if (bit_cnt == 5'h07) begin
              cmd_byte <= {1'b0, next_cmd}; // [R01] [R07]
              bit_cnt  <= 5'h00;
              xfer_len <= reg_len(next_cmd[5:3]);  // [R09] [R17]
              if (next_cmd[6]) begin        // [R08]
                if (next_cmd[5:3] == `ACP_SEL_DATA && next_cmd[2]) begin
                  state       <= acp_pkg::ACP_ST_STREAM;  // [R10]
                  hist        <= 8'h00;
                  stream_busy <= 1'b0;
                end else begin
                  state     <= acp_pkg::ACP_ST_READ;
                  load_pipe <= 2'b01;
                end
              end else if (next_cmd[5:3] != `ACP_SEL_COMM) begin
                state <= acp_pkg::ACP_ST_WRITE;
              end
            end else begin
              cmd_sr  <= next_cmd;          // [R05]
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
          acp_pkg::ACP_ST_WRITE: begin
            in_sr <= {in_sr[22:0], din_f};  // [R20]
            if (bit_cnt == xfer_len - 5'h01) begin
              state   <= acp_pkg::ACP_ST_IDLE;  // [R02]
              bit_cnt <= 5'h00;
              wr_en   <= 1'b1;
            end else begin
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
          acp_pkg::ACP_ST_READ: begin
            if (bit_cnt == xfer_len - 5'h01) begin
              state   <= acp_pkg::ACP_ST_IDLE;  // [R02]
              bit_cnt <= 5'h00;
              rd_done <= (sel == `ACP_SEL_DATA);
            end else begin
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
          acp_pkg::ACP_ST_STREAM: begin
            hist <= next_hist;              // [R14]
            if (next_hist == `ACP_CMD_EXIT && data_ready) begin
              state       <= acp_pkg::ACP_ST_IDLE;  // [R13]
              bit_cnt     <= 5'h00;
              stream_busy <= 1'b0;
            end else if (stream_busy) begin
              if (bit_cnt == LEN_WORD - 5'h01) begin
                stream_busy <= 1'b0;        // [R11]
                bit_cnt     <= 5'h00;
                rd_done     <= 1'b1;
              end else begin
                bit_cnt <= bit_cnt + 5'h01;
              end
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // register bank
  // ****************************************************************
  acp_regbank #(
    .DW        (DW),
    .CFG_RESET (CFG_RESET),
    .OFS_RESET (OFS_RESET),
    .FS_RESET  (FS_RESET)
  ) u_bank (
    .clk            (CLOCK),
    .rst            (rst_all),
    .wr_en          (wr_en && (sel == `ACP_SEL_MODE || sel == `ACP_SEL_CONFIG ||
                               sel == `ACP_SEL_OFFSET || sel == `ACP_SEL_FULLSCALE)),
    .wr_addr        (sel),
    .wr_data        (in_sr & ~(24'hFFFFFF << xfer_len)),
    .rd_addr        (sel),
    .rd_data        (rd_data),
    .mode_word      (MODE_WORD),
    .config_word    (CONFIG_WORD),
    .offset_word    (OFFSET_WORD),
    .fullscale_word (FULLSCALE_WORD)
  );

  // ****************************************************************
  // conversion result and ready flag
  // ****************************************************************
  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      data_reg <= 24'h000000;
    end else if (CONV_DONE) begin
      data_reg <= CONV_DATA & ~(24'hFFFFFF << LEN_WORD);
    end
  end

  // ready: set by a new result, cleared by a data read, a pending update or a mode write
  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      data_ready <= 1'b0;
    end else if (CONV_DONE) begin
      data_ready <= 1'b1;                   // [R18]
    end else if (rd_done || CONV_WARN || (wr_en && sel == `ACP_SEL_MODE)) begin
      data_ready <= 1'b0;                   // [R18]
    end
  end

  // ****************************************************************
  // output shifter and shared pin
  // ****************************************************************
  assign status_byte = {~data_ready, CONV_ERR, 3'b000, CONV_CHAN};
  assign shifting    = (state == acp_pkg::ACP_ST_READ) ||
                       (state == acp_pkg::ACP_ST_STREAM && stream_busy);

  // value presented for a read, chosen by the select field
  always_comb begin
    load_val = 24'h000000;
    unique case (sel)
      `ACP_SEL_COMM:  load_val = {16'h0000, status_byte};
      `ACP_SEL_DATA:  load_val = data_reg;
      `ACP_SEL_IDENT: load_val = {16'h0000, ID_CODE};
      `ACP_SEL_RESV:  load_val = 24'h000000;
      default:        load_val = rd_data;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      out_sr   <= 24'h000000;
      dout_bit <= 1'b1;
    end else if (load_pipe[1] || stream_load) begin
      out_sr   <= left_align(stream_load ? data_reg : load_val,
                             stream_load ? LEN_WORD : xfer_len);  // [R20]
      dout_bit <= ~stream_load;             // stream keeps ready low until first fall [R10]
    end else if (sck_fall && shifting) begin
      dout_bit <= out_sr[23];               // [R19]
      out_sr   <= {out_sr[22:0], 1'b0};
    end
  end

  // pin shows data while shifting, otherwise the inverted ready flag
  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      DOUT_RDY <= 1'b1;
    end else begin
      DOUT_RDY <= shifting ? dout_bit : ~data_ready;  // [R18]
    end
  end

  // output enable follows the filtered select only, a part reset keeps the pin driven
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      DOUT_OE <= 1'b0;
    end else begin
      DOUT_OE <= ~cs_f;                     // [R19]
    end
  end

endmodule

// >>> bench/acp_port_checker.sv
// concurrent checks on the serial command port pins
// assumes binding onto acp_serial_port, one CLOCK domain
`timescale 1ns/1ps

module acp_port_checker (
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  input wire logic        CS_N,
  input wire logic        DOUT_RDY,
  input wire logic        DOUT_OE,
  input wire logic        CONV_DONE,
  input wire logic        CONV_WARN,
  input wire logic        PART_RESET,
  input wire logic [23:0] MODE_WORD,
  input wire logic [23:0] CONFIG_WORD,
  input wire logic [23:0] OFFSET_WORD
);
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  // interface idle and mode word at reset value after release
  reset_idle_a: assert property ($fell(SYS_RST) |-> DOUT_RDY && !DOUT_OE
    && !PART_RESET && MODE_WORD == 24'h00000A) else $error("bad state after reset");
  // part reset is a single pulse
  reset_pulse_a: assert property (PART_RESET |=> !PART_RESET)
    else $error("part reset longer than one cycle");
  // part reset restores the mode word
  reset_mode_a: assert property (PART_RESET |-> ##[1:2] MODE_WORD == 24'h00000A)
    else $error("mode word not restored by part reset");
  // output driven only while selected
  oe_on_a: assert property (!CS_N [*6] |-> DOUT_OE)
    else $error("output not driven while selected");
  oe_off_a: assert property (CS_N [*6] |-> !DOUT_OE)
    else $error("output driven while deselected");
  // conversion end pulls the shared pin low
  done_low_a: assert property (CONV_DONE && CS_N |-> ##[1:3] !DOUT_RDY)
    else $error("ready pin not low after conversion");
  // pending update returns an unread result pin high
  warn_high_a: assert property (CONV_WARN && !CONV_DONE && CS_N |-> ##[1:3] DOUT_RDY)
    else $error("ready pin not high before update");
  // no mode, config or offset word change without serial traffic
  bank_hold_a: assert property (CS_N [*8] |-> $stable(CONFIG_WORD)
    && $stable(OFFSET_WORD) && $stable(MODE_WORD)) else $error("bank changed while idle");
endmodule

bind acp_serial_port acp_port_checker chk_u (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .CS_N(CS_N), .DOUT_RDY(DOUT_RDY),
  .DOUT_OE(DOUT_OE), .CONV_DONE(CONV_DONE), .CONV_WARN(CONV_WARN),
  .PART_RESET(PART_RESET), .MODE_WORD(MODE_WORD), .CONFIG_WORD(CONFIG_WORD),
  .OFFSET_WORD(OFFSET_WORD)
);

// >>> bench/acp_host_model.sv
// serial master model: drives the select, clock and data lines
// assumes the clock idles high and frames run at a 125 ns bit period
`timescale 1ns/1ps

module acp_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  // ****************************************************************
  // idle levels
  // ****************************************************************
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  // one frame of n bits, msb first, captured bits returned in rx
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    cs_n = 1'b0;
    #62.5;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      din = tx[i];                 // drive on fall, device samples on rise
      #62.5;
      rx = {rx[30:0], dout};       // output valid at the rise
      sclk = 1'b1;
      #62.5;
    end
    din = 1'b0;                    // data held low between commands
    cs_n = 1'b1;
    #125;
  endtask
endmodule

// >>> bench/tb.sv
// self-checking bench of the serial command port
// assumes acp_host_model as serial master and converter pulses from the bench
`timescale 1ns/1ps

module tb;
  logic        clock, sys_rst, conv_done, conv_warn, conv_err;
  logic [23:0] conv_data;
  logic [2:0]  conv_chan;
  logic        sclk, cs_n, din, dout_rdy, dout_oe, part_reset;
  logic [23:0] mode_word, config_word, offset_word, fullscale_word;
  logic [31:0] rx;
  int          n_fail, tests_run, cycles, n_resets;

  // ****************************************************************
  // design, host and clock
  // ****************************************************************
  acp_serial_port #(.ID_CODE(8'h3C), .FS_RESET(24'h400000)) dut_u (
    .CLOCK(clock), .SYS_RST(sys_rst), .SCLK(sclk), .CS_N(cs_n), .DIN(din),
    .DOUT_RDY(dout_rdy), .DOUT_OE(dout_oe), .CONV_DONE(conv_done),
    .CONV_WARN(conv_warn), .CONV_DATA(conv_data), .CONV_ERR(conv_err),
    .CONV_CHAN(conv_chan), .PART_RESET(part_reset), .MODE_WORD(mode_word),
    .CONFIG_WORD(config_word), .OFFSET_WORD(offset_word),
    .FULLSCALE_WORD(fullscale_word));
  // released output line rests at its pull-up level
  acp_host_model host_u (.sclk(sclk), .cs_n(cs_n), .din(din),
                         .dout(dout_oe ? dout_rdy : 1'b1));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // part reset watch and hang limit
  always @(posedge clock) begin
    cycles++;
    if (part_reset === 1'b1) n_resets++;
    if (cycles == 20000) begin
      n_fail++;
      close_out();
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] c, input int n, input logic [31:0] e);
    host_u.xfer({24'h0, c}, 8, rx);
    host_u.xfer(32'h0, n, rx);
    check(rx, e, "read");
  endtask

  task automatic wr(input logic [7:0] c, input int n, input logic [31:0] v);
    host_u.xfer({24'h0, c}, 8, rx);
    host_u.xfer(v, n, rx);
  endtask

  task automatic conv(input logic [23:0] d, input logic warn);
    @(negedge clock);
    conv_data = d;
    conv_done = ~warn;
    conv_warn = warn;
    @(negedge clock);
    conv_done = 1'b0;
    conv_warn = 1'b0;
    repeat (6) @(negedge clock);
  endtask

  task automatic close_out();
    $display("n_fail %0d tests_run %0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    sys_rst = 1'b1;
    conv_done = 1'b0;
    conv_warn = 1'b0;
    conv_err = 1'b1;
    conv_chan = 3'h5;
    conv_data = 24'h000000;
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    repeat (6) @(negedge clock);
    check({dout_rdy, dout_oe}, 32'h2, "pins after reset");
    check(mode_word, 24'h00000A, "mode reset");
    check(offset_word, 24'h800000, "offset reset");
    check(fullscale_word, 24'h400000, "fullscale reset");
    rd(8'h40, 8, 32'hC5);
    host_u.xfer(32'h7, 3, rx);
    rd(8'h48, 16, 32'h000A);
    wr(8'h08, 16, 32'h1234);
    check(mode_word[15:0], 32'h1234, "mode write");
    rd(8'h48, 16, 32'h1234);
    wr(8'h10, 16, 32'hBEEF);
    check(config_word[15:0], 32'hBEEF, "config write");
    wr(8'h30, 24, 32'h123456);
    check(offset_word, 24'h123456, "offset write");
    rd(8'h70, 24, 32'h123456);
    rd(8'h78, 24, 32'h400000);
    wr(8'h20, 8, 32'hFF);
    rd(8'h60, 8, 32'h3C);
    conv(24'hA5C3E1, 1'b0);
    check(dout_rdy, 32'h0, "ready low");
    rd(8'h58, 24, 32'hA5C3E1);
    check(dout_rdy, 32'h1, "ready after read");
    conv(24'h111111, 1'b0);
    conv(24'h111111, 1'b1);
    check(dout_rdy, 32'h1, "ready after warn");
    host_u.xfer(32'h5C, 8, rx);
    conv(24'h3C4B5A, 1'b0);
    host_u.xfer(32'h0, 24, rx);
    check(rx, 32'h3C4B5A, "stream first");
    conv(24'h0F1E2D, 1'b0);
    host_u.xfer(32'h0, 24, rx);
    check(rx, 32'h0F1E2D, "stream second");
    conv(24'h777777, 1'b0);
    host_u.xfer(32'h58, 8, rx);
    check(rx, 32'h77, "stream bits during exit");
    rd(8'h60, 8, 32'h3C);
    wr(8'h08, 16, 32'h4321);
    host_u.xfer(32'hFFFFFFFF, 32, rx);
    check({n_resets == 1, mode_word}, 32'h100000A, "ones reset");
    rd(8'h60, 8, 32'h3C);
    host_u.xfer(32'h5C, 8, rx);
    host_u.xfer(32'hFFFFFFFF, 32, rx);
    check(n_resets, 32'h2, "ones reset in stream");
    rd(8'h60, 8, 32'h3C);
    close_out();
  end
endmodule
